// [design/scms_defines.vh]
/*
 Constants for the stop control and power mode status register block.
 Assumes inclusion by bare name from design files.
*/
`ifndef SCMS_DEFINES_VH
`define SCMS_DEFINES_VH

`define SCMS_ADDR_W 4
`define SCMS_OFF_STOP_FINE 4'h2
`define SCMS_OFF_MODE_STATE 4'h3
`define SCMS_OFF_MODE_REQ 4'h4

`define SCMS_POS_DET_OFF 5
`define SCMS_STOP_FINE_RESET 8'h00
`define SCMS_STOP_FINE_WMASK 8'hE7

`define SCMS_SEL_NORMAL_HALT 3'h0
`define SCMS_SEL_VLP_HALT 3'h2
`define SCMS_SEL_LL_HALT 3'h3
`define SCMS_SEL_VLL_HALT 3'h4

`define SCMS_SUB_VLL0 3'h0
`define SCMS_SUB_VLL1 3'h1
`define SCMS_SUB_VLL3 3'h7

`define SCMS_PH_NONE 2'h0
`define SCMS_PH_SYS_BUS 2'h1
`define SCMS_PH_SYS_ONLY 2'h2

`define SCMS_ST_RUN 7'h01
`define SCMS_ST_HALT 7'h02
`define SCMS_ST_LP_RUN 7'h04
`define SCMS_ST_LP_WAIT 7'h08
`define SCMS_ST_LP_HALT 7'h10
`define SCMS_ST_LL_HALT 7'h20
`define SCMS_ST_VLL_HALT 7'h40

`define SCMS_MODE_RUN 3'h0
`define SCMS_MODE_HALT 3'h1
`define SCMS_MODE_LP_RUN 3'h2
`define SCMS_MODE_LP_WAIT 3'h3
`define SCMS_MODE_LP_HALT 3'h4
`define SCMS_MODE_LL_HALT 3'h5
`define SCMS_MODE_VLL_HALT 3'h6

`endif

// [design/scms_mode_code.v]
/*
 Maps a mode number to its one-hot status code.
 Assumes a mode number from the main block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scms_defines.vh"
module scms_mode_code (
   input wire [2:0] mode,
   output reg [6:0] code
);
   always @* begin
      case (mode)
         `SCMS_MODE_RUN: code = `SCMS_ST_RUN;
         `SCMS_MODE_HALT: code = `SCMS_ST_HALT;
         `SCMS_MODE_LP_RUN: code = `SCMS_ST_LP_RUN;
         `SCMS_MODE_LP_WAIT: code = `SCMS_ST_LP_WAIT;
         `SCMS_MODE_LP_HALT: code = `SCMS_ST_LP_HALT;
         `SCMS_MODE_LL_HALT: code = `SCMS_ST_LL_HALT;
         `SCMS_MODE_VLL_HALT: code = `SCMS_ST_VLL_HALT;
         default: code = `SCMS_ST_RUN;
      endcase
   end
endmodule
`default_nettype wire

// [design/scms_stop_control_mode_status.v]
/*
 Stop fine control and power mode status registers on Avalon-MM.
 Assumes rst_n is the chip power-on reset that excludes deep wakeup;
 mode completion, debug and the stop kind select come from pins.
*/
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "scms_defines.vh"
module scms_stop_control_mode_status (
   input wire clock,
   input wire rst_n,
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   input wire [2:0] stop_kind_select,
   input wire [2:0] done_mode,
   input wire mode_done,
   input wire debug_enable,
   output reg reset_detector_off,
   output reg [2:0] leakage_submode_select,
   output reg [1:0] partial_halt_option,
   output reg [2:0] req_stop_kind,
   output reg stop_kind_invalid
);
   localparam [2:0] BUS_IDLE = 3'b001;
   localparam [2:0] BUS_ACK = 3'b010;
   localparam [2:0] BUS_DONE = 3'b100;

   reg [2:0] bus_state;
   reg [2:0] next_bus_state;
   reg [7:0] stop_fine_control;
   reg [6:0] power_mode_state;
   reg [2:0] kind_meta_in;
   wire [2:0] kind_sync;
   wire [2:0] mode_sync;
   wire done_sync;
   wire debug_sync;
   reg done_prev;
   wire [6:0] done_code;
   wire blocked;
   wire is_halt_code;
   wire sub_ok;
   wire kind_ok;

   scms_sync #(.W(8)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({stop_kind_select, done_mode, mode_done, debug_enable}),
      .sync_out({kind_sync, mode_sync, done_sync, debug_sync})
   );

   scms_mode_code u_code (
      .mode(mode_sync),
      .code(done_code)
   );

   always @* begin
      kind_meta_in = kind_sync;
   end

   // Halt and LP halt codes held back under debug or partial halt
   assign is_halt_code = (done_code == `SCMS_ST_HALT) ||
      (done_code == `SCMS_ST_LP_HALT);
   assign blocked = is_halt_code && (debug_sync ||
      (stop_fine_control[7:6] != `SCMS_PH_NONE));
   assign sub_ok = (stop_fine_control[2:0] == `SCMS_SUB_VLL0) ||
      (stop_fine_control[2:0] == `SCMS_SUB_VLL1) ||
      (stop_fine_control[2:0] == `SCMS_SUB_VLL3);
   assign kind_ok = (kind_meta_in == `SCMS_SEL_NORMAL_HALT) ||
      (kind_meta_in == `SCMS_SEL_VLP_HALT) ||
      (kind_meta_in == `SCMS_SEL_LL_HALT) ||
      (kind_meta_in == `SCMS_SEL_VLL_HALT);

   // Bus handshake: one wait cycle, then acknowledge
   always @* begin
      case (bus_state)
         BUS_IDLE: next_bus_state = (read || write) ? BUS_ACK : BUS_IDLE;
         BUS_ACK: next_bus_state = BUS_DONE;
         BUS_DONE: next_bus_state = BUS_IDLE;
         default: next_bus_state = BUS_IDLE;
      endcase
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_state <= BUS_IDLE;
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
      end else begin
         bus_state <= next_bus_state;
         waitrequest <= !(next_bus_state == BUS_ACK);
         if (next_bus_state == BUS_ACK && read) begin
            case (address)
               `SCMS_OFF_STOP_FINE:
                  readdata <= {24'h00_0000, stop_fine_control};
               `SCMS_OFF_MODE_STATE:
                  readdata <= {25'h000_0000, power_mode_state};
               `SCMS_OFF_MODE_REQ:
                  readdata <= {28'h000_0000, stop_kind_invalid,
                     req_stop_kind};
               default: readdata <= 32'h0000_0000;
            endcase
         end else begin
            readdata <= 32'h0000_0000;
         end
      end
   end

   // Register writes and status tracking
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stop_fine_control <= `SCMS_STOP_FINE_RESET;
         power_mode_state <= `SCMS_ST_RUN;
         done_prev <= 1'b0;
      end else begin
         done_prev <= done_sync;
         if (bus_state == BUS_ACK && write &&
            address == `SCMS_OFF_STOP_FINE) begin
            // Bits four and three never stored
            stop_fine_control <= writedata[7:0] &
               `SCMS_STOP_FINE_WMASK;
         end
         if (done_sync && !done_prev && !blocked) begin
            power_mode_state <= done_code;
         end
      end
   end

   // Control outputs, registered
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_detector_off <= 1'b0;
         leakage_submode_select <= `SCMS_SUB_VLL0;
         partial_halt_option <= `SCMS_PH_NONE;
         req_stop_kind <= `SCMS_SEL_NORMAL_HALT;
         stop_kind_invalid <= 1'b0;
      end else begin
         // Detector off only in the deepest submode
         reset_detector_off <= stop_fine_control[`SCMS_POS_DET_OFF] &&
            (kind_meta_in == `SCMS_SEL_VLL_HALT) &&
            (stop_fine_control[2:0] == `SCMS_SUB_VLL0);
         leakage_submode_select <= stop_fine_control[2:0];
         // Partial option only applies to normal halt
         partial_halt_option <= (kind_meta_in == `SCMS_SEL_NORMAL_HALT &&
            stop_fine_control[7:6] != 2'h3) ?
            stop_fine_control[7:6] : `SCMS_PH_NONE;
         req_stop_kind <= kind_meta_in;
         stop_kind_invalid <= !kind_ok ||
            ((kind_meta_in == `SCMS_SEL_VLL_HALT) && !sub_ok);
      end
   end
endmodule
`default_nettype wire

// [design/scms_sync.v]
/*
 Two flip-flop synchroniser for a bus of level inputs.
 Assumes inputs asynchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module scms_sync #(
   parameter W = 1
) (
   input wire clock,
   input wire rst_n,
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] meta;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// [verification/scms_asserts.sv]
/* Port checker for the stop control and mode status block.
 Assumes the top module's port names. */
`timescale 1ns/1ps
`default_nettype none
module scms_asserts (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic reset_detector_off,
   input wire logic [2:0] leakage_submode_select,
   input wire logic [1:0] partial_halt_option,
   input wire logic [2:0] req_stop_kind,
   input wire logic stop_kind_invalid
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire logic ack = !waitrequest && read;
   property p_ack; (read || write) && waitrequest |-> ##[1:3] !waitrequest;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_one; !waitrequest |=> waitrequest; endproperty
   a_one: assert property (p_one) else $error("long ack");
   property p_st; ack && address == 4'h3 |->
      $onehot(readdata[6:0]) && readdata[31:7] == 0; endproperty
   a_st: assert property (p_st) else $error("status code");
   property p_rsv; ack && address == 4'h2 |->
      readdata[4:3] == 2'b00 && readdata[31:8] == 0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits");
   property p_det; reset_detector_off && $stable(req_stop_kind) |->
      req_stop_kind == 3'h4 && leakage_submode_select == 3'h0; endproperty
   a_det: assert property (p_det) else $error("detector off");
   property p_inv; (req_stop_kind == 3'h5) [*3] |-> stop_kind_invalid;
   endproperty
   a_inv: assert property (p_inv) else $error("kind valid");
   property p_vld; (req_stop_kind == 3'h2) [*3] |-> !stop_kind_invalid;
   endproperty
   a_vld: assert property (p_vld) else $error("kind invalid");
   property p_ph; partial_halt_option != 2'h0 && $stable(req_stop_kind)
      |-> partial_halt_option != 2'h3 && req_stop_kind == 3'h0; endproperty
   a_ph: assert property (p_ph) else $error("partial halt");
endmodule
bind scms_stop_control_mode_status scms_asserts i_chk (.*);
`default_nettype wire

// [verification/scms_testbench.sv]
/* Self-checking bench of the block over Avalon-MM.
 Assumes design files and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock = 0, rst_n = 0, read = 0, write = 0;
   logic mode_done = 0, debug_enable = 0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0000_0000, q;
   logic [2:0] stop_kind_select = 3'h0, done_mode = 3'h0;
   wire logic [31:0] readdata;
   wire logic waitrequest, reset_detector_off, stop_kind_invalid;
   wire logic [2:0] leakage_submode_select, req_stop_kind;
   wire logic [1:0] partial_halt_option;
   int mismatches = 0, checks_done = 0;
   scms_stop_control_mode_status i_dut (.*);
   initial forever #5 clock = ~clock;
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int n = 0;
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      @(posedge clock);
      while (waitrequest !== 1'b0 && n < 50) begin
         @(posedge clock);
         n++;
      end
      if (n >= 50) mismatches++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   task automatic mode(input logic [2:0] m);
      done_mode <= m;
      cyc(2);
      mode_done <= 1'b1;
      cyc(8);
      mode_done <= 1'b0;
      cyc(4);
   endtask
   task automatic t_regs;
      rd(4'h2, 32'h0000_0000);
      rd(4'h3, 32'h0000_0001);
      bus(1'b1, 4'h2, 32'hFFFF_FFFF);
      rd(4'h2, 32'h0000_00E7);
      bus(1'b1, 4'h3, 32'h0000_0040);
      rd(4'h3, 32'h0000_0001);
      rd(4'h9, 32'h0000_0000);
      bus(1'b1, 4'h2, 32'h0000_0000);
      for (int m = 0; m < 7; m++) begin
         mode(m[2:0]);
         rd(4'h3, 32'h0000_0001 << m);
      end
      $display("test regs and modes done");
   endtask
   task automatic t_block;
      debug_enable <= 1'b1;
      mode(3'h1);
      rd(4'h3, 32'h0000_0040);
      mode(3'h4);
      rd(4'h3, 32'h0000_0040);
      mode(3'h5);
      debug_enable <= 1'b0;
      bus(1'b1, 4'h2, 32'h0000_0040);
      mode(3'h1);
      rd(4'h3, 32'h0000_0020);
      $display("test blocking done");
   endtask
   task automatic t_kind;
      for (int k = 0; k < 8; k++) begin
         stop_kind_select <= k[2:0];
         bus(1'b1, 4'h2, 32'h0000_0060);
         cyc(6);
         chk(req_stop_kind, k[2:0]);
         chk(stop_kind_invalid, k inside {1, 5, 6, 7});
         chk(reset_detector_off, k == 4);
         chk(partial_halt_option, k == 0);
      end
      stop_kind_select <= 3'h4;
      bus(1'b1, 4'h2, 32'h0000_0026);
      cyc(6);
      chk(stop_kind_invalid, 1'b1);
      bus(1'b1, 4'h2, 32'h0000_0027);
      cyc(6);
      chk(stop_kind_invalid, 1'b0);
      chk(leakage_submode_select, 3'h7);
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      rd(4'h3, 32'h0000_0001);
      rd(4'h2, 32'h0000_0000);
      $display("test kinds and reset done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      cyc(12);
      rst_n <= 1'b1;
      cyc(1);
      t_regs;
      t_block;
      t_kind;
      report_and_stop;
   end
   initial begin
      cyc(20000);
      mismatches++;
      report_and_stop;
   end
endmodule
`default_nettype wire
